// file: rtl/video_decoder_serial_regs.sv
// video decoder control and status registers behind the serial control bus
`timescale 1ns/1ps
module video_decoder_serial_regs #(
  parameter logic [6:0]  DEV_ADDR_LOW  = 7'h43,
  parameter logic [6:0]  DEV_ADDR_HIGH = 7'h47,
  // identity values are arbitrary
  parameter logic [7:0]  MAKER_ID      = 8'h5a,
  parameter logic [15:0] PART_NUMBER   = 16'h1234,
  parameter logic [7:0]  MAKER_ID2     = 8'ha5,
  parameter int          RAM_DATA_W    = 12
) (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  input  wire logic                      addr_strap,
  input  wire logic                      vsync,
  input  wire vdec_pkg::slicer_stat_type slicer_stat,
  output vdec_pkg::slicer_cfg_type       slicer_cfg,
  output logic [7:0]                     low_power_cfg,
  output logic [7:0]                     output_drive_enable,
  output logic [7:0]                     pad_enables_fast,
  output logic [7:0]                     pad_enables_slow,
  output vdec_pkg::ram_cmd_type          ram_cmd,
  input  wire logic [RAM_DATA_W-1:0]     ram_rdata,
  input  wire logic                      ram_ack
);

  // ==================================================
  // elaboration checks
  if (RAM_DATA_W < 1 || RAM_DATA_W > 16) begin : g_bad_width
    $error("RAM_DATA_W must lie in 1..16");
  end

  localparam logic [15:0] DATA_MASK = 16'((17'h1 << RAM_DATA_W) - 17'h1);

  // ==================================================
  // address strap, caught once after reset release
  logic [1:0] strap_sync_q;
  logic       strap_q;
  logic       strap_d;
  logic       strap_done_q;
  logic       strap_done_d;

  always_comb begin
    strap_d      = strap_q;
    strap_done_d = 1'b1;
    if (!strap_done_q) begin
      strap_d = strap_sync_q[1];
    end
  end

  // synchroniser left unreset: a static strap needs no defined start
  always_ff @(posedge clk) begin
    strap_sync_q <= {strap_sync_q[0], addr_strap};
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      strap_q      <= 1'b0;
      strap_done_q <= 1'b0;
    end else begin
      strap_q      <= strap_d;
      strap_done_q <= strap_done_d;
    end
  end

  // ==================================================
  // byte engine
  logic       addr_p;
  logic       read_mode;
  logic       byte_p;
  logic [7:0] rx_byte;
  logic       take_p;
  logic [7:0] rd_byte;

  serial_byte_link u_link (
    .clk       (clk),
    .rstn      (rstn),
    .dev_addr  (strap_q ? DEV_ADDR_HIGH : DEV_ADDR_LOW),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .tx_byte   (rd_byte),
    .sda_oe    (sda_oe),
    .addr_p    (addr_p),
    .read_mode (read_mode),
    .byte_p    (byte_p),
    .byte_data (rx_byte),
    .take_p    (take_p)
  );

  assign sda_out = 1'b0;

  // ==================================================
  // subaddress pointer and byte pairing
  logic [7:0] sub_q;
  logic [7:0] sub_d;
  logic       have_sub_q;
  logic       have_sub_d;
  logic       phase_q;
  logic       phase_d;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic       byte_we;
  logic       pair_we;
  logic       is_pair;

  assign is_pair = (sub_q == vdec_pkg::OFS_GW_RD) ||
                   (sub_q == vdec_pkg::OFS_GW_WR) ||
                   (sub_q == vdec_pkg::OFS_GW_DATA);

  always_comb begin
    sub_d      = sub_q;
    have_sub_d = have_sub_q;
    phase_d    = phase_q;
    hi_d       = hi_q;
    byte_we    = 1'b0;
    pair_we    = 1'b0;
    if (addr_p) begin
      phase_d = 1'b0;
      if (!read_mode) begin
        have_sub_d = 1'b0;
      end
    end else if (byte_p) begin
      if (!have_sub_q) begin
        sub_d      = rx_byte;
        have_sub_d = 1'b1;
      end else if (is_pair) begin
        if (!phase_q) begin
          hi_d    = rx_byte;
          phase_d = 1'b1;
        end else begin
          pair_we = 1'b1;
          phase_d = 1'b0;
        end
      end else begin
        byte_we = 1'b1;
        sub_d   = sub_q + 8'h01;
      end
    end else if (take_p) begin
      // wide registers stay put so a host can stream pairs; bytes step on
      if (is_pair) begin
        phase_d = ~phase_q;
      end else begin
        sub_d = sub_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sub_q      <= 8'h00;
      have_sub_q <= 1'b0;
      phase_q    <= 1'b0;
      hi_q       <= 8'h00;
    end else begin
      sub_q      <= sub_d;
      have_sub_q <= have_sub_d;
      phase_q    <= phase_d;
      hi_q       <= hi_d;
    end
  end

  // ==================================================
  // configuration registers
  logic [7:0]       low_power_q, low_power_d;
  logic [7:0]       out_en_q, out_en_d;
  logic [7:0]       pad_fast_q, pad_fast_d;
  logic [7:0]       pad_slow_q, pad_slow_d;
  logic [15:0][7:0] hold_q, hold_d;
  logic [15:0][7:0] act_q, act_d;

  always_comb begin
    low_power_d = low_power_q;
    out_en_d    = out_en_q;
    pad_fast_d  = pad_fast_q;
    pad_slow_d  = pad_slow_q;
    hold_d      = hold_q;
    // a write in the vsync cycle lands in holding and waits a field
    act_d       = vsync ? hold_q : act_q;
    if (byte_we) begin
      case (sub_q)
        vdec_pkg::OFS_LOW_POWER: begin
          low_power_d = rx_byte;
        end
        vdec_pkg::OFS_OUT_EN: begin
          out_en_d = rx_byte;
        end
        vdec_pkg::OFS_PAD_FAST: begin
          pad_fast_d = rx_byte;
        end
        vdec_pkg::OFS_PAD_SLOW: begin
          pad_slow_d = rx_byte;
        end
        default: begin
          low_power_d = low_power_q;
        end
      endcase
      for (int i = 0; i < vdec_pkg::SLICE_REGS; i++) begin
        if (sub_q == vdec_pkg::SLICE_OFS[i]) begin
          hold_d[i] = rx_byte;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_power_q <= vdec_pkg::RST_LOW_POWER;
      out_en_q    <= vdec_pkg::RST_OUT_EN;
      pad_fast_q  <= vdec_pkg::RST_PAD;
      pad_slow_q  <= vdec_pkg::RST_PAD;
      hold_q      <= {vdec_pkg::SLICE_REGS{vdec_pkg::RST_SLICE}};
      act_q       <= {vdec_pkg::SLICE_REGS{vdec_pkg::RST_SLICE}};
    end else begin
      low_power_q <= low_power_d;
      out_en_q    <= out_en_d;
      pad_fast_q  <= pad_fast_d;
      pad_slow_q  <= pad_slow_d;
      hold_q      <= hold_d;
      act_q       <= act_d;
    end
  end

  assign slicer_cfg          = vdec_pkg::slicer_cfg_type'(act_q);
  assign low_power_cfg       = low_power_q;
  assign output_drive_enable = out_en_q;

  // ==================================================
  // pad buffer enables
  logic [7:0] pad_en_fast_q, pad_en_fast_d;
  logic [7:0] pad_en_slow_q, pad_en_slow_d;

  always_comb begin
    for (int i = 0; i < vdec_pkg::PAD_BUFFERS; i++) begin
      pad_en_fast_d[i] = 3'(i) <= pad_fast_q[vdec_pkg::STRENGTH_W-1:0];
      pad_en_slow_d[i] = 3'(i) <= pad_slow_q[vdec_pkg::STRENGTH_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pad_en_fast_q <= 8'h1f;
      pad_en_slow_q <= 8'h1f;
    end else begin
      pad_en_fast_q <= pad_en_fast_d;
      pad_en_slow_q <= pad_en_slow_d;
    end
  end

  assign pad_enables_fast = pad_en_fast_q;
  assign pad_enables_slow = pad_en_slow_q;

  // ==================================================
  // processor ram gateway
  vdec_pkg::gw_state_type gw_q, gw_d;
  logic [15:0] rd_addr_q, rd_addr_d;
  logic [15:0] wr_addr_q, wr_addr_d;
  logic [15:0] data_q, data_d;
  logic        armed_q, armed_d;
  logic [7:0]  gw_status;

  always_comb begin
    gw_d      = gw_q;
    rd_addr_d = rd_addr_q;
    wr_addr_d = wr_addr_q;
    data_d    = data_q;
    armed_d   = armed_q;
    // gateway writes while busy are dropped so the request stands; host polls status
    if (pair_we && gw_q == vdec_pkg::gw_idle) begin
      case (sub_q)
        vdec_pkg::OFS_GW_RD: begin
          rd_addr_d = {hi_q, rx_byte};
          if (gw_q == vdec_pkg::gw_idle) begin
            gw_d = vdec_pkg::gw_read;
          end
        end
        vdec_pkg::OFS_GW_WR: begin
          wr_addr_d = {hi_q, rx_byte};
          armed_d   = 1'b1;
        end
        vdec_pkg::OFS_GW_DATA: begin
          data_d = {hi_q, rx_byte} & DATA_MASK;
          if (armed_q) begin
            gw_d = vdec_pkg::gw_write;
          end
        end
        default: begin
          armed_d = armed_q;
        end
      endcase
    end
    case (gw_q)
      vdec_pkg::gw_read: begin
        if (ram_ack) begin
          data_d = 16'(ram_rdata);
          gw_d   = vdec_pkg::gw_idle;
        end
      end
      vdec_pkg::gw_write: begin
        if (ram_ack) begin
          wr_addr_d = wr_addr_q + 16'h0001;
          gw_d      = vdec_pkg::gw_idle;
        end
      end
      default: begin
        gw_d = gw_d;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      gw_q      <= vdec_pkg::gw_idle;
      rd_addr_q <= vdec_pkg::RST_GW;
      wr_addr_q <= vdec_pkg::RST_GW;
      data_q    <= vdec_pkg::RST_GW;
      armed_q   <= 1'b0;
    end else begin
      gw_q      <= gw_d;
      rd_addr_q <= rd_addr_d;
      wr_addr_q <= wr_addr_d;
      data_q    <= data_d;
      armed_q   <= armed_d;
    end
  end

  always_comb begin
    gw_status                         = 8'h00;
    gw_status[vdec_pkg::GW_BUSY_BIT]  = gw_q != vdec_pkg::gw_idle;
    gw_status[vdec_pkg::GW_ARMED_BIT] = armed_q;
  end

  always_comb begin
    ram_cmd.req   = gw_q != vdec_pkg::gw_idle;
    ram_cmd.we    = gw_q == vdec_pkg::gw_write;
    ram_cmd.addr  = (gw_q == vdec_pkg::gw_write) ? wr_addr_q : rd_addr_q;
    ram_cmd.wdata = data_q;
  end

  // ==================================================
  // readback
  always_comb begin
    case (sub_q)
      vdec_pkg::OFS_MAKER: begin
        rd_byte = MAKER_ID;
      end
      vdec_pkg::OFS_PART_HI: begin
        rd_byte = PART_NUMBER[15:8];
      end
      vdec_pkg::OFS_PART_LO: begin
        rd_byte = PART_NUMBER[7:0];
      end
      vdec_pkg::OFS_MAKER2: begin
        rd_byte = MAKER_ID2;
      end
      vdec_pkg::OFS_GW_STATUS: begin
        rd_byte = gw_status;
      end
      vdec_pkg::OFS_GW_DATA: begin
        rd_byte = phase_q ? data_q[7:0] : data_q[15:8];
      end
      vdec_pkg::OFS_SOFT_ERR: begin
        rd_byte = slicer_stat.soft_errors;
      end
      vdec_pkg::OFS_SYNC_STATE: begin
        rd_byte = slicer_stat.sync_state;
      end
      vdec_pkg::OFS_HSYNC: begin
        rd_byte = slicer_stat.hsync_tally;
      end
      vdec_pkg::OFS_COEF_RB: begin
        rd_byte = slicer_stat.coef_readback;
      end
      vdec_pkg::OFS_LEVEL_RB: begin
        rd_byte = slicer_stat.level_readback;
      end
      default: begin
        // write-only and unmapped offsets read as zero
        rd_byte = 8'h00;
      end
    endcase
  end

endmodule

// file: rtl/vdec_pkg.sv
// package: offsets, defaults, carriers and states of the decoder register bank
package vdec_pkg;

  // ==================================================
  // register offsets
  localparam logic [7:0] OFS_MAKER      = 8'h00;
  localparam logic [7:0] OFS_PART_HI    = 8'h01;
  localparam logic [7:0] OFS_PART_LO    = 8'h02;
  localparam logic [7:0] OFS_MAKER2     = 8'h03;
  localparam logic [7:0] OFS_GW_STATUS  = 8'h35;
  localparam logic [7:0] OFS_GW_RD      = 8'h36;
  localparam logic [7:0] OFS_GW_WR      = 8'h37;
  localparam logic [7:0] OFS_GW_DATA    = 8'h38;
  localparam logic [7:0] OFS_LOW_POWER  = 8'haa;
  localparam logic [7:0] OFS_SOFT_ERR   = 8'hb3;
  localparam logic [7:0] OFS_SYNC_STATE = 8'hb4;
  localparam logic [7:0] OFS_HSYNC      = 8'hb5;
  localparam logic [7:0] OFS_COEF_RB    = 8'hb6;
  localparam logic [7:0] OFS_LEVEL_RB   = 8'hb7;
  localparam logic [7:0] OFS_OUT_EN     = 8'hf2;
  localparam logic [7:0] OFS_PAD_FAST   = 8'hf8;
  localparam logic [7:0] OFS_PAD_SLOW   = 8'hf9;

  // slicer settings, slot 15 first: masks, patterns, levels, rate, modes
  localparam int SLICE_REGS = 16;
  localparam logic [15:0][7:0] SLICE_OFS = {
    8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hc0, 8'hc1,
    8'hc2, 8'hc5, 8'hc6, 8'hc7, 8'hc8, 8'hc9, 8'hce, 8'hcf};

  // ==================================================
  // defaults and fields
  localparam logic [7:0]  RST_LOW_POWER = 8'h00;
  localparam logic [7:0]  RST_SLICE     = 8'h00;
  localparam logic [7:0]  RST_OUT_EN    = 8'h00;
  localparam logic [7:0]  RST_PAD       = 8'h04;
  localparam logic [15:0] RST_GW        = 16'h0000;
  localparam int          GW_BUSY_BIT   = 0;
  localparam int          GW_ARMED_BIT  = 1;
  localparam int          STRENGTH_W    = 3;
  localparam int          PAD_BUFFERS   = 8;

  // ==================================================
  // carriers and states
  typedef struct packed {
    logic [7:0] mask_hi;
    logic [7:0] mask_mid;
    logic [7:0] mask_lo;
    logic [7:0] pattern_hi;
    logic [7:0] pattern_mid;
    logic [7:0] pattern_lo;
    logic [7:0] soft_level;
    logic [7:0] rate_lo;
    logic [7:0] rate_hi;
    logic [7:0] filter_coef;
    logic [7:0] bit_level;
    logic [7:0] accumulator;
    logic [7:0] sync_level;
    logic [7:0] standard;
    logic [7:0] error_allowance;
    logic [7:0] byte_total;
  } slicer_cfg_type;

  typedef struct packed {
    logic [7:0] soft_errors;
    logic [7:0] sync_state;
    logic [7:0] hsync_tally;
    logic [7:0] coef_readback;
    logic [7:0] level_readback;
  } slicer_stat_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ram_cmd_type;

  typedef enum logic [2:0] {
    ls_idle     = 3'b000,
    ls_addr     = 3'b001,
    ls_addr_ack = 3'b011,
    ls_rx       = 3'b010,
    ls_rx_ack   = 3'b110,
    ls_tx       = 3'b111,
    ls_tx_ack   = 3'b101,
    ls_skip     = 3'b100
  } link_state_type;

  typedef enum logic [1:0] {
    gw_idle  = 2'b00,
    gw_read  = 2'b01,
    gw_write = 2'b11
  } gw_state_type;

endpackage

// file: rtl/serial_byte_link.sv
// serial control bus byte engine: start/stop, address match, byte shift, ack
`timescale 1ns/1ps
module serial_byte_link (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [6:0] dev_addr,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [7:0] tx_byte,
  output logic            sda_oe,
  output logic            addr_p,
  output logic            read_mode,
  output logic            byte_p,
  output logic [7:0]      byte_data,
  output logic            take_p
);

  // ==================================================
  // pin synchronisers
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_prev_q;
  logic       sda_prev_q;
  logic       scl;
  logic       sda;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;

  assign scl   = scl_sync_q[1];
  assign sda   = sda_sync_q[1];
  assign rise  = scl & ~scl_prev_q;
  assign fall  = ~scl & scl_prev_q;
  assign start = scl & scl_prev_q & sda_prev_q & ~sda;
  assign stop  = scl & scl_prev_q & ~sda_prev_q & sda;

  // ==================================================
  // byte state machine
  vdec_pkg::link_state_type st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, data_q, data_d;
  logic       rw_q, rw_d, drive_q, drive_d, nack_q, nack_d;
  logic       addr_d, addr_q, byte_d, byte_q, take_d, take_q;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    data_d  = data_q;
    rw_d    = rw_q;
    drive_d = drive_q;
    nack_d  = nack_q;
    addr_d  = 1'b0;
    byte_d  = 1'b0;
    take_d  = 1'b0;
    if (stop) begin
      st_d    = vdec_pkg::ls_idle;
      drive_d = 1'b0;
    end else if (start) begin
      st_d    = vdec_pkg::ls_addr;
      cnt_d   = 4'h0;
      drive_d = 1'b0;
    end else begin
      case (st_q)
        vdec_pkg::ls_addr, vdec_pkg::ls_rx: begin
          if (rise) begin
            sh_d  = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == 4'h8) begin
            if (st_q == vdec_pkg::ls_rx) begin
              data_d  = sh_q;
              byte_d  = 1'b1;
              drive_d = 1'b1;
              st_d    = vdec_pkg::ls_rx_ack;
            end else if (sh_q[7:1] == dev_addr) begin
              rw_d    = sh_q[0];
              addr_d  = 1'b1;
              drive_d = 1'b1;
              st_d    = vdec_pkg::ls_addr_ack;
            end else begin
              st_d = vdec_pkg::ls_skip;
            end
          end
        end
        vdec_pkg::ls_addr_ack, vdec_pkg::ls_rx_ack: begin
          if (fall) begin
            drive_d = 1'b0;
            cnt_d   = 4'h0;
            st_d    = vdec_pkg::ls_rx;
            if (st_q == vdec_pkg::ls_addr_ack && rw_q) begin
              sh_d    = tx_byte;
              drive_d = ~tx_byte[7];
              take_d  = 1'b1;
              st_d    = vdec_pkg::ls_tx;
            end
          end
        end
        vdec_pkg::ls_tx: begin
          if (rise) begin
            cnt_d = cnt_q + 4'h1;
            sh_d  = {sh_q[6:0], 1'b0};
          end else if (fall) begin
            drive_d = (cnt_q == 4'h8) ? 1'b0 : ~sh_q[7];
            if (cnt_q == 4'h8) begin
              st_d = vdec_pkg::ls_tx_ack;
            end
          end
        end
        vdec_pkg::ls_tx_ack: begin
          if (rise) begin
            nack_d = sda;
          end else if (fall) begin
            st_d = vdec_pkg::ls_skip;
            if (!nack_q) begin
              sh_d    = tx_byte;
              drive_d = ~tx_byte[7];
              cnt_d   = 4'h0;
              take_d  = 1'b1;
              st_d    = vdec_pkg::ls_tx;
            end
          end
        end
        vdec_pkg::ls_idle, vdec_pkg::ls_skip: begin
          st_d = st_q;
        end
        default: begin
          st_d = vdec_pkg::ls_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      st_q       <= vdec_pkg::ls_idle;
      cnt_q      <= 4'h0;
      sh_q       <= 8'h00;
      data_q     <= 8'h00;
      rw_q       <= 1'b0;
      drive_q    <= 1'b0;
      nack_q     <= 1'b0;
      addr_q     <= 1'b0;
      byte_q     <= 1'b0;
      take_q     <= 1'b0;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl;
      sda_prev_q <= sda;
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      sh_q       <= sh_d;
      data_q     <= data_d;
      rw_q       <= rw_d;
      drive_q    <= drive_d;
      nack_q     <= nack_d;
      addr_q     <= addr_d;
      byte_q     <= byte_d;
      take_q     <= take_d;
    end
  end

  assign sda_oe    = drive_q;
  assign addr_p    = addr_q;
  assign read_mode = rw_q;
  assign byte_p    = byte_q;
  assign byte_data = data_q;
  // the tx byte is sampled by this engine, so the bank may offer it combinationally
  assign take_p    = take_d;

endmodule

// file: test/vdec_properties.sv
// checker: port-level properties of the decoder register bank
`timescale 1ns/1ps
module vdec_properties #(
  parameter int RAM_DATA_W = 12
) (
  input wire logic                     clk,
  input wire logic                     rstn,
  input wire logic                     scl_in,
  input wire logic                     sda_oe,
  input wire logic                     vsync,
  input wire vdec_pkg::slicer_cfg_type slicer_cfg,
  input wire logic [7:0]               low_power_cfg,
  input wire logic [7:0]               pad_enables_fast,
  input wire logic [7:0]               pad_enables_slow,
  input wire vdec_pkg::ram_cmd_type    ram_cmd,
  input wire logic                     ram_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========
  // reset
  a_reset_values:
    assert property (disable iff (1'b0) !rstn |=> !sda_oe && !ram_cmd.req && slicer_cfg == '0 && low_power_cfg == '0)
    else $error("reset value wrong");
  a_reset_pads:
    assert property (disable iff (1'b0) !rstn |=> pad_enables_fast == 8'h1f && pad_enables_slow == 8'h1f)
    else $error("pad default wrong");
  // ==========
  // settings and pads
  a_vsync_gate:
    assert property (!vsync |=> $stable(slicer_cfg)) else $error("slicer setting moved without vsync");
  a_pad_thermo_fast:
    assert property (pad_enables_fast[0] && (pad_enables_fast & (pad_enables_fast + 8'h01)) == 8'h00)
    else $error("fast pad enables not contiguous");
  a_pad_thermo_slow:
    assert property (pad_enables_slow[0] && (pad_enables_slow & (pad_enables_slow + 8'h01)) == 8'h00)
    else $error("slow pad enables not contiguous");
  // a fast pad change needs an acked data byte around it
  a_pad_on_ack:
    assert property ($past(rstn) && $changed(pad_enables_fast) |-> sda_oe || $past(sda_oe))
    else $error("pad strength changed outside a write");
  // ==========
  // bus pin and gateway
  a_sda_on_low:
    assert property ($past(rstn) && $changed(sda_oe) |-> !scl_in) else $error("data pin moved while clock high");
  a_ram_hold:
    assert property (ram_cmd.req && !ram_ack |=> ram_cmd.req && $stable(ram_cmd)) else $error("request not held");
  a_ram_drop:
    assert property (ram_ack |=> !ram_cmd.req) else $error("request outlived its answer");
  a_wdata_upper:
    assert property (ram_cmd.req && ram_cmd.we |-> (ram_cmd.wdata >> RAM_DATA_W) == 16'h0)
    else $error("unused data bits not zero");
endmodule

bind video_decoder_serial_regs vdec_properties #(.RAM_DATA_W(RAM_DATA_W)) props (
  .clk(clk), .rstn(rstn), .scl_in(scl_in), .sda_oe(sda_oe), .vsync(vsync), .slicer_cfg(slicer_cfg),
  .low_power_cfg(low_power_cfg), .pad_enables_fast(pad_enables_fast), .pad_enables_slow(pad_enables_slow),
  .ram_cmd(ram_cmd), .ram_ack(ram_ack));

// file: test/ctl_host.sv
// partner: serial control bus host that configures the decoder
`timescale 1ns/1ps
module ctl_host (
  input  wire logic clk,
  input  wire logic dev_oe,
  output logic      scl = 1'b1,
  output logic      sda
);
  logic pull_q = 1'b0;
  logic nak_q = 1'b0;
  // open drain with pull-up: a released line reads high
  assign sda = !(pull_q || dev_oe);
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ==========
  // bus phases, four or more clocks each for margin on the synchronisers
  task automatic edge_bit(input logic b, output logic r);
    hold(4);
    pull_q <= !b;
    hold(4);
    scl <= 1'b1;
    hold(5);
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic start();
    hold(4);
    pull_q <= 1'b0;
    hold(4);
    scl <= 1'b1;
    hold(5);
    pull_q <= 1'b1;
    hold(5);
    scl <= 1'b0;
  endtask
  task automatic stop();
    hold(4);
    pull_q <= 1'b1;
    hold(4);
    scl <= 1'b1;
    hold(5);
    pull_q <= 1'b0;
    hold(5);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ackbit, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) edge_bit(d[i], q[i]);
    edge_bit(ackbit, a);
  endtask
  task automatic wb(input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    xfer(d, 1'b1, q, a);
    if (a) nak_q = 1'b1;
  endtask
  // ==========
  // register access: wide registers as two bytes, high first, upper bits zero
  task automatic wr(input logic [7:0] sub, input logic [15:0] d, input int n);
    start();
    wb(8'h86);
    wb(sub);
    if (n == 2) wb(d[15:8]);
    wb(d[7:0]);
    stop();
  endtask
  task automatic rd(input logic [7:0] sub, input int n, output logic [15:0] v);
    logic [7:0] q;
    logic       a;
    start();
    wb(8'h86);
    wb(sub);
    start();
    wb(8'h87);
    v = '0;
    for (int i = 1; i <= n; i++) begin
      xfer(8'hff, i == n, q, a);
      v = {v[7:0], q};
    end
    stop();
  endtask
endmodule

// file: test/tb_top.sv
// testbench: register bank driven through the serial control bus host
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0] sub;
    logic [7:0] data;
    logic [7:0] exp;
  } row_type;
  logic                      clk = 1'b0;
  logic                      rstn;
  logic                      vsync;
  logic                      scl;
  logic                      sda;
  logic                      sda_oe;
  logic                      ram_ack = 1'b0;
  logic [11:0]               ram_rdata = 12'h543;
  logic [7:0]                low_power_cfg;
  logic [7:0]                out_en;
  logic [7:0]                pad_fast;
  logic [7:0]                pad_slow;
  vdec_pkg::slicer_stat_type stat;
  vdec_pkg::slicer_cfg_type  cfg;
  vdec_pkg::ram_cmd_type     cmd;
  vdec_pkg::ram_cmd_type     seen;
  logic [15:0]               v;
  int                        wait_q;
  int                        err_total;
  int                        cmp_count;
  row_type                   rows [6];

  video_decoder_serial_regs uut (
    .clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .addr_strap(1'b0),
    .vsync(vsync), .slicer_stat(stat), .slicer_cfg(cfg), .low_power_cfg(low_power_cfg),
    .output_drive_enable(out_en), .pad_enables_fast(pad_fast), .pad_enables_slow(pad_slow),
    .ram_cmd(cmd), .ram_rdata(ram_rdata), .ram_ack(ram_ack));
  ctl_host host (.clk(clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));

  always #10 clk = ~clk;
  // ==========
  // slow gateway partner; read data is junk outside the answer cycle
  always @(posedge clk) begin
    wait_q <= (cmd.req && !ram_ack) ? wait_q + 1 : 0;
    ram_ack <= (wait_q == 6);
    ram_rdata <= (wait_q == 6) ? 12'habc : 12'h543;
    if (wait_q == 6) seen <= cmd;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic poll();
    for (int i = 0; i < 20; i++) begin
      host.rd(8'h35, 1, v);
      if (v[0] === 1'b0) return;
    end
    err_total++;
    stop_test();
  endtask
  function automatic logic [7:0] pick(input logic [7:0] sub);
    case (sub)
      8'haa: return low_power_cfg;
      8'hf2: return out_en;
      8'hf8: return pad_fast;
      default: return pad_slow;
    endcase
  endfunction

  initial begin
    rstn = 1'b0;
    vsync = 1'b0;
    err_total = 0;
    cmp_count = 0;
    stat = {8'h3c, 32'h0};
    rows = '{'{8'haa, 8'h5c, 8'h5c}, '{8'hf2, 8'ha3, 8'ha3}, '{8'hf8, 8'h04, 8'h1f},
             '{8'hf9, 8'h0d, 8'h3f}, '{8'hf8, 8'h07, 8'hff}, '{8'hf9, 8'h00, 8'h01}};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk({pad_fast, pad_slow}, 16'h1f1f);
    chk({low_power_cfg, out_en}, 16'h0);
    foreach (rows[i]) begin
      host.wr(rows[i].sub, {8'h00, rows[i].data}, 1);
      repeat (2) @(posedge clk);
      chk(pick(rows[i].sub), rows[i].exp);
    end
    // ==========
    // identity, read-only and write-only places
    host.wr(8'h00, 16'h0011, 1);
    host.rd(8'h00, 2, v);
    chk(v, 16'h5a12);
    host.rd(8'h02, 2, v);
    chk(v, 16'h34a5);
    host.rd(8'haa, 1, v);
    chk(v, 16'h0000);
    host.rd(8'hb3, 1, v);
    chk(v, 16'h003c);
    // ==========
    // vsync latching
    host.wr(8'hb8, 16'h009e, 1);
    chk(cfg.mask_hi, 8'h00);
    vsync <= 1'b1;
    @(posedge clk);
    vsync <= 1'b0;
    repeat (2) @(posedge clk);
    chk(cfg.mask_hi, 8'h9e);
    // ==========
    // gateway: lone high byte, read, then armed write
    host.wr(8'h36, 16'h0005, 1);
    repeat (4) @(posedge clk);
    chk(cmd.req, 1'b0);
    host.wr(8'h36, 16'h0013, 2);
    poll();
    chk(v, 16'h0000);
    chk({seen.we, seen.addr[14:0]}, 16'h0013);
    host.rd(8'h38, 2, v);
    chk(v, 16'h0abc);
    host.wr(8'h37, 16'h0120, 2);
    host.wr(8'h38, 16'h0fed, 2);
    poll();
    chk(v, 16'h0002);
    chk({seen.we, seen.addr[14:0]}, 16'h8120);
    chk(seen.wdata, 16'h0fed);
    chk(host.nak_q, 1'b0);
    // ==========
    // second reset in mid-run
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk({pad_fast, cfg.mask_hi}, 16'h1f00);
    stop_test();
  end
endmodule
